// ---- logic/tccc_top.sv ----
// Added by the designer: the APB interface to the registers and the register addresses.
`timescale 1ns/1ns
module tccc_top (
  // clock and reset
  input  wire logic                     sys_clk,
  input  wire logic                     reset,
  // apb slave
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [tccc_pkg::AD_W-1:0] paddr,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  // pins
  input  wire logic                     extIn,
  input  wire logic                     saIn,
  input  wire logic                     daIn,
  output logic                          saOut,
  output logic                          daOut,
  // interrupt requests, one-cycle pulses
  output logic [tccc_pkg::NCNT-1:0]     cntIrq,
  output logic                          saIrq,
  output logic                          daIrq
);
  localparam int TW = tccc_pkg::TB_W;

  function automatic logic at(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  tccc_pkg::tccc_cnt_ctrl_t cntCtrl_reg [tccc_pkg::NCNT];
  logic [TW-1:0]            cnt_reg     [tccc_pkg::NCNT];
  logic [tccc_pkg::NCNT-1:0] stepped_reg;
  logic [TW-1:0]            modVal_reg;
  tccc_pkg::tccc_sa_ctrl_t  saCtrl_reg;
  tccc_pkg::tccc_da_ctrl_t  daCtrl_reg;
  logic [TW-1:0]            saVal_reg;
  logic [TW-1:0]            primary_value_reg;
  logic [TW-1:0]            first_stage_reg;
  logic [TW-1:0]            second_stage_reg;
  logic [tccc_pkg::PRE_W-1:0] pre_reg;
  logic [tccc_pkg::PRE_W-1:0] preTick;
  logic                     extPrev_reg, saPrev_reg, daPrev_reg;
  logic                     aArm_reg, bArm_reg;
  logic                     wrEn, rdCap, addrOk;
  logic [31:0]              rdNext;

  // apb: one wait state, so read data is a flop and stays coherent
  assign wrEn  = psel && penable && pready && pwrite;
  assign rdCap = psel && penable && !pready;
  assign addrOk = (paddr[1:0] == 2'h0) && (paddr <= tccc_pkg::ADDR_DA_PAIR);

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= tccc_pkg::RD_ZERO;
    end else begin
      pready <= rdCap;
      if (rdCap) begin
        pslverr <= !addrOk;
        prdata  <= pwrite ? tccc_pkg::RD_ZERO : rdNext;
      end
    end
  end

  always_comb begin
    rdNext = tccc_pkg::RD_ZERO;
    for (int g = 0; g < tccc_pkg::NCNT; g++) begin
      if (at(paddr, tccc_pkg::ADDR_CNT_CTRL + 8'(g) * tccc_pkg::CNT_STRIDE))
        rdNext = 32'(cntCtrl_reg[g]);
      if (at(paddr, tccc_pkg::ADDR_CNT_VAL + 8'(g) * tccc_pkg::CNT_STRIDE))
        rdNext = 32'(cnt_reg[g]);
    end
    if (at(paddr, tccc_pkg::ADDR_MOD_VAL)) rdNext = 32'(modVal_reg);
    if (at(paddr, tccc_pkg::ADDR_SA_CTRL)) rdNext = 32'(saCtrl_reg);
    if (at(paddr, tccc_pkg::ADDR_SA_VAL))  rdNext = 32'(saVal_reg);
    if (at(paddr, tccc_pkg::ADDR_DA_CTRL)) rdNext = 32'(daCtrl_reg);
    if (at(paddr, tccc_pkg::ADDR_DA_A))    rdNext = 32'(primary_value_reg);
    if (at(paddr, tccc_pkg::ADDR_DA_B))    rdNext = 32'(second_stage_reg);
    if (at(paddr, tccc_pkg::ADDR_DA_PAIR))
      rdNext = {primary_value_reg, second_stage_reg};
  end

  // prescaler taps; tap k pulses once every 2^(k+1) cycles
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pre_reg     <= '0;
      extPrev_reg <= 1'b0;
      saPrev_reg  <= 1'b0;
      daPrev_reg  <= 1'b0;
    end else begin
      pre_reg     <= pre_reg + 1'b1;
      extPrev_reg <= extIn;
      saPrev_reg  <= saIn;
      daPrev_reg  <= daIn;
    end
  end

  for (genvar k = 0; k < tccc_pkg::PRE_W; k++) begin : gTap
    assign preTick[k] = &pre_reg[k:0];
  end

  function automatic logic stepOf(input logic [2:0] sel,
                                  input logic [tccc_pkg::PRE_W-1:0] tk,
                                  input logic rise, input logic fall);
    if (sel == tccc_pkg::CLK_EXT_RISE) return rise;
    if (sel == tccc_pkg::CLK_EXT_FALL) return fall;
    return tk[sel];
  endfunction

  // counter 0 is free-running, counter 1 reloads the modulus
  for (genvar g = 0; g < tccc_pkg::NCNT; g++) begin : gCnt
    logic step, wrCtrl, wrCnt, wrap;
    assign step = stepOf(cntCtrl_reg[g].clkSel, preTick,
                         extIn && !extPrev_reg, !extIn && extPrev_reg);
    assign wrCtrl = wrEn && at(paddr, tccc_pkg::ADDR_CNT_CTRL
                               + 8'(g) * tccc_pkg::CNT_STRIDE);
    assign wrCnt  = wrEn && at(paddr, tccc_pkg::ADDR_CNT_VAL
                               + 8'(g) * tccc_pkg::CNT_STRIDE);
    assign wrap   = step && (cnt_reg[g] == tccc_pkg::TB_ONES) && !wrCnt;

    always_ff @(posedge sys_clk) begin
      if (reset) begin
        cntCtrl_reg[g] <= '0;
        cnt_reg[g]     <= tccc_pkg::TB_ZERO;
        stepped_reg[g] <= 1'b0;
        cntIrq[g]      <= 1'b0;
      end else begin
        if (wrCtrl)
          cntCtrl_reg[g] <= pwdata[tccc_pkg::CNT_CTRL_W-1:0];
        if (wrCnt)
          cnt_reg[g] <= pwdata[TW-1:0];
        else if (wrap)
          cnt_reg[g] <= (g == 1) ? modVal_reg : tccc_pkg::TB_ZERO;
        else if (step)
          cnt_reg[g] <= cnt_reg[g] + 1'b1;
        stepped_reg[g] <= step || wrCnt;
        cntIrq[g]      <= wrap && cntCtrl_reg[g].irqEn;
      end
    end
  end

  // channel side decode
  logic [TW-1:0] saBus, daBus, mask;
  logic          saFresh, daFresh, saEdge, lead, trail, saMatch;
  logic          matchA, matchB, wrSaVal, wrDaA, wrDaB, fireA, fireB;

  assign saBus   = cnt_reg[saCtrl_reg.busSel];
  assign saFresh = stepped_reg[saCtrl_reg.busSel];
  assign daBus   = cnt_reg[daCtrl_reg.busSel];
  assign daFresh = stepped_reg[daCtrl_reg.busSel];
  assign saEdge  = saCtrl_reg.risePol ? (saIn && !saPrev_reg)
                                      : (!saIn && saPrev_reg);
  assign lead    = daCtrl_reg.risePol ? (daIn && !daPrev_reg)
                                      : (!daIn && daPrev_reg);
  assign trail   = daCtrl_reg.risePol ? (!daIn && daPrev_reg)
                                      : (daIn && !daPrev_reg);
  assign wrSaVal = wrEn && at(paddr, tccc_pkg::ADDR_SA_VAL);
  assign wrDaA   = wrEn && at(paddr, tccc_pkg::ADDR_DA_A);
  assign wrDaB   = wrEn && at(paddr, tccc_pkg::ADDR_DA_B);
  // masked high bits shorten the period by a power of two
  assign mask    = tccc_pkg::TB_ONES >> daCtrl_reg.maskBits;
  // a match only counts on a fresh time-base value, so a stopped
  // counter cannot fire the same compare every cycle
  assign saMatch = saCtrl_reg.cmpMode && saFresh && (saBus == saVal_reg);
  assign matchA  = daFresh && ((daBus & mask) == (primary_value_reg & mask));
  assign matchB  = daFresh && ((daBus & mask) == (second_stage_reg & mask));
  assign fireA   = matchA && ((daCtrl_reg.mode == tccc_pkg::DA_PWM) ||
                   (daCtrl_reg.mode == tccc_pkg::DA_PULSE && aArm_reg));
  assign fireB   = !fireA && matchB &&
                   ((daCtrl_reg.mode == tccc_pkg::DA_PWM) ||
                   (daCtrl_reg.mode == tccc_pkg::DA_PULSE && bArm_reg));

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      modVal_reg <= tccc_pkg::TB_ZERO;
      saCtrl_reg <= '0;
      daCtrl_reg <= '0;
    end else if (wrEn) begin
      if (at(paddr, tccc_pkg::ADDR_MOD_VAL)) modVal_reg <= pwdata[TW-1:0];
      if (at(paddr, tccc_pkg::ADDR_SA_CTRL))
        saCtrl_reg <= pwdata[tccc_pkg::SA_CTRL_W-1:0];
      if (at(paddr, tccc_pkg::ADDR_DA_CTRL))
        daCtrl_reg <= pwdata[tccc_pkg::DA_CTRL_W-1:0];
    end
  end

  // single-action channel
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      saVal_reg <= tccc_pkg::TB_ZERO;
      saOut     <= 1'b0;
      saIrq     <= 1'b0;
    end else begin
      if (wrSaVal)
        saVal_reg <= pwdata[TW-1:0];
      else if (!saCtrl_reg.cmpMode && saEdge)
        saVal_reg <= saBus;
      if (saMatch) begin
        unique case (saCtrl_reg.act)
          tccc_pkg::SA_TOGGLE: saOut <= !saOut;
          tccc_pkg::SA_SET:    saOut <= 1'b1;
          tccc_pkg::SA_CLEAR:  saOut <= 1'b0;
          tccc_pkg::SA_HOLD:   saOut <= saOut;
        endcase
      end
      saIrq <= saCtrl_reg.irqEn &&
               (saCtrl_reg.cmpMode ? saMatch : saEdge);
    end
  end

  // double-action channel stages; a software write beats hardware
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      primary_value_reg <= tccc_pkg::TB_ZERO;
      first_stage_reg   <= tccc_pkg::TB_ZERO;
      second_stage_reg  <= tccc_pkg::TB_ZERO;
    end else if (wrDaA) begin
      primary_value_reg <= pwdata[TW-1:0];
    end else if (wrDaB) begin
      if (daCtrl_reg.mode == tccc_pkg::DA_PULSE)
        second_stage_reg <= pwdata[TW-1:0];
      else
        first_stage_reg <= pwdata[TW-1:0];
    end else begin
      unique case (daCtrl_reg.mode)
        tccc_pkg::DA_WIDTH: begin
          if (lead)
            first_stage_reg <= daBus;
          if (trail) begin
            primary_value_reg <= daBus;
            second_stage_reg  <= first_stage_reg;
          end
        end
        tccc_pkg::DA_PERIOD: begin
          if (lead) begin
            primary_value_reg <= daBus;
            second_stage_reg  <= first_stage_reg;
            first_stage_reg   <= daBus;
          end
        end
        tccc_pkg::DA_PWM: begin
          if (fireA)
            second_stage_reg <= first_stage_reg;
        end
        tccc_pkg::DA_PULSE: begin
        end
      endcase
    end
  end

  // pulse arming: a write re-arms even if a match clears it that cycle
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      aArm_reg <= 1'b0;
      bArm_reg <= 1'b0;
    end else begin
      aArm_reg <= wrDaA || (aArm_reg && !fireA);
      bArm_reg <= (wrDaB && daCtrl_reg.mode == tccc_pkg::DA_PULSE) ||
                  (bArm_reg && !fireB);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      daOut <= 1'b0;
      daIrq <= 1'b0;
    end else begin
      if (fireA)
        daOut <= daCtrl_reg.risePol;
      else if (fireB)
        daOut <= !daCtrl_reg.risePol;
      unique case (daCtrl_reg.mode)
        tccc_pkg::DA_WIDTH:
          daIrq <= daCtrl_reg.irqEn &&
                   (trail || (daCtrl_reg.firstIrq && lead));
        tccc_pkg::DA_PERIOD:
          daIrq <= daCtrl_reg.irqEn && lead;
        tccc_pkg::DA_PULSE:
          daIrq <= daCtrl_reg.irqEn &&
                   (fireB || (daCtrl_reg.firstIrq && fireA));
        tccc_pkg::DA_PWM:
          daIrq <= daCtrl_reg.irqEn && fireA;
      endcase
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  chk_sa_capture_value: assert property (
    !saCtrl_reg.cmpMode && saEdge && !wrSaVal |=> saVal_reg == $past(saBus))
    else $error("capture value wrong");
  chk_sa_capture_irq: assert property (
    saCtrl_reg.irqEn && !saCtrl_reg.cmpMode && saEdge |=> saIrq)
    else $error("capture request missing");
  chk_width_lead_store: assert property (
    daCtrl_reg.mode == tccc_pkg::DA_WIDTH && lead && !wrDaA && !wrDaB
    |=> first_stage_reg == $past(daBus))
    else $error("leading edge not stored");
  chk_width_trail_move: assert property (
    daCtrl_reg.mode == tccc_pkg::DA_WIDTH && trail && !wrDaA && !wrDaB
    |=> second_stage_reg == $past(first_stage_reg)
        && primary_value_reg == $past(daBus))
    else $error("trailing edge transfer wrong");
  chk_period_order: assert property (
    daCtrl_reg.mode == tccc_pkg::DA_PERIOD && lead && !wrDaA && !wrDaB
    |=> first_stage_reg == primary_value_reg
        && second_stage_reg == $past(first_stage_reg))
    else $error("period update order wrong");
  chk_sa_toggle_pin: assert property (
    saMatch && saCtrl_reg.act == tccc_pkg::SA_TOGGLE |=> saOut != $past(saOut))
    else $error("compare toggle missing");
  chk_pwm_lead_edge: assert property (
    daCtrl_reg.mode == tccc_pkg::DA_PWM && fireA && !wrDaA && !wrDaB
    |=> daOut == $past(daCtrl_reg.risePol)
        && second_stage_reg == $past(first_stage_reg))
    else $error("pwm leading edge wrong");
  chk_pair_read_word: assert property (
    rdCap && !pwrite && at(paddr, tccc_pkg::ADDR_DA_PAIR)
    |=> prdata == {$past(primary_value_reg), $past(second_stage_reg)}
        && pready)
    else $error("pair read not coherent");
  chk_mod_reload: assert property (
    gCnt[1].wrap |=> cnt_reg[1] == $past(modVal_reg)
                     && cntIrq[1] == $past(cntCtrl_reg[1].irqEn))
    else $error("modulus reload wrong");

  cov_width_pulse: cover property (
    daCtrl_reg.mode == tccc_pkg::DA_WIDTH && lead ##[1:200] trail);
  cov_single_pulse: cover property (
    daCtrl_reg.mode == tccc_pkg::DA_PULSE && fireA ##[1:500] fireB);
  cov_sa_compare: cover property (saMatch);
  cov_mod_wrap: cover property (cntIrq[1]);
endmodule // tccc_top

// ---- logic/tccc_pkg.sv ----
package tccc_pkg;
  localparam int TB_W  = 16;
  localparam int PRE_W = 6;
  localparam int AD_W  = 8;
  localparam int NCNT  = 2;

  // register byte offsets
  localparam logic [7:0] ADDR_CNT_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CNT_VAL  = 8'h04;
  localparam logic [7:0] CNT_STRIDE    = 8'h08;
  localparam logic [7:0] ADDR_MOD_VAL  = 8'h10;
  localparam logic [7:0] ADDR_SA_CTRL  = 8'h14;
  localparam logic [7:0] ADDR_SA_VAL   = 8'h18;
  localparam logic [7:0] ADDR_DA_CTRL  = 8'h1c;
  localparam logic [7:0] ADDR_DA_A     = 8'h20;
  localparam logic [7:0] ADDR_DA_B     = 8'h24;
  localparam logic [7:0] ADDR_DA_PAIR  = 8'h28;

  // counter clock sources: 0..5 prescaler taps /2../64
  localparam logic [2:0] CLK_EXT_RISE = 3'h6;
  localparam logic [2:0] CLK_EXT_FALL = 3'h7;

  localparam logic [TB_W-1:0] TB_ZERO = 16'h0000;
  localparam logic [TB_W-1:0] TB_ONES = 16'hffff;
  localparam logic [31:0]     RD_ZERO = 32'h0000_0000;

  typedef enum logic [1:0] {
    DA_WIDTH  = 2'h0,
    DA_PERIOD = 2'h1,
    DA_PULSE  = 2'h2,
    DA_PWM    = 2'h3
  } tccc_da_mode_t;

  typedef enum logic [1:0] {
    SA_TOGGLE = 2'h0,
    SA_SET    = 2'h1,
    SA_CLEAR  = 2'h2,
    SA_HOLD   = 2'h3
  } tccc_sa_act_t;

  typedef struct packed {
    logic         irqEn;
    tccc_sa_act_t act;
    logic         busSel;
    logic         risePol;
    logic         cmpMode;
  } tccc_sa_ctrl_t;

  typedef struct packed {
    logic [2:0]    maskBits;
    logic          firstIrq;
    logic          irqEn;
    logic          busSel;
    logic          risePol;
    tccc_da_mode_t mode;
  } tccc_da_ctrl_t;

  typedef struct packed {
    logic       irqEn;
    logic [2:0] clkSel;
  } tccc_cnt_ctrl_t;

  localparam int SA_CTRL_W  = $bits(tccc_sa_ctrl_t);
  localparam int DA_CTRL_W  = $bits(tccc_da_ctrl_t);
  localparam int CNT_CTRL_W = $bits(tccc_cnt_ctrl_t);
endpackage

// ---- verification/tccc_pin_model.sv ----
`timescale 1ns/1ns
module tccc_pin_model (
  // clock
  input  wire logic sys_clk,
  // channel output pins
  input  wire logic saOut,
  input  wire logic daOut,
  // pins into the block
  output logic      extIn,
  output logic      saIn,
  output logic      daIn,
  // edge counts of the output pins
  output int        saEdges,
  output int        daEdges
);
  logic saLast, daLast;

  initial begin
    {extIn, saIn, daIn, saLast, daLast} = 0;
    {saEdges, daEdges} = 0;
  end

  // an unknown level never counts as an edge
  always @(posedge sys_clk) begin
    if ((saOut ^ saLast) === 1'b1) saEdges <= saEdges + 1;
    if ((daOut ^ daLast) === 1'b1) daEdges <= daEdges + 1;
    saLast <= saOut;
    daLast <= daOut;
  end

  // a level stands four edges so the input sampler sees every change
  task automatic drive(input int pin, input logic v);
    @(posedge sys_clk);
    case (pin)
      0: extIn <= v;
      1: saIn <= v;
      default: daIn <= v;
    endcase
    repeat (3) @(posedge sys_clk);
  endtask
endmodule // tccc_pin_model

// ---- verification/tb_timer_capture_compare_channels.sv ----
`timescale 1ns/1ns
module tb_timer_capture_compare_channels;
  localparam logic [7:0] CC0 = tccc_pkg::ADDR_CNT_CTRL;
  localparam logic [7:0] CV0 = tccc_pkg::ADDR_CNT_VAL;
  localparam logic [7:0] CC1 = CC0 + tccc_pkg::CNT_STRIDE;
  localparam logic [7:0] CV1 = CV0 + tccc_pkg::CNT_STRIDE;
  localparam logic [7:0] SAC = tccc_pkg::ADDR_SA_CTRL;
  localparam logic [7:0] SAV = tccc_pkg::ADDR_SA_VAL;
  localparam logic [7:0] DAC = tccc_pkg::ADDR_DA_CTRL;
  localparam logic [7:0] DAA = tccc_pkg::ADDR_DA_A;
  localparam logic [7:0] DAB = tccc_pkg::ADDR_DA_B;
  localparam logic [7:0] DAP = tccc_pkg::ADDR_DA_PAIR;
  localparam int         LIMIT = 20000;

  logic                      sys_clk, reset, psel, penable, pwrite, err;
  logic                      pready, pslverr, extIn, saIn, daIn;
  logic                      saOut, daOut, saIrq, daIrq;
  logic [tccc_pkg::AD_W-1:0] paddr;
  logic [31:0]               pwdata, prdata, rd;
  logic [tccc_pkg::NCNT-1:0] cntIrq;
  logic [15:0]               cnt;
  int                        n_errors, cmp_count, cycles, saEdges, daEdges;
  int                        nSaIrq, nDaIrq, nC0Irq, nC1Irq;
  int                        runHi, runLo, lastHi, lastLo;

  tccc_top dut_u (
    .sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .extIn(extIn), .saIn(saIn),
    .daIn(daIn), .saOut(saOut), .daOut(daOut), .cntIrq(cntIrq),
    .saIrq(saIrq), .daIrq(daIrq)
  );

  tccc_pin_model pins_u (
    .sys_clk(sys_clk), .saOut(saOut), .daOut(daOut), .extIn(extIn),
    .saIn(saIn), .daIn(daIn), .saEdges(saEdges), .daEdges(daEdges)
  );

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // request pulses and output run lengths, counted from the pins
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    nSaIrq <= nSaIrq + int'(saIrq === 1'b1);
    nDaIrq <= nDaIrq + int'(daIrq === 1'b1);
    nC0Irq <= nC0Irq + int'(cntIrq[0] === 1'b1);
    nC1Irq <= nC1Irq + int'(cntIrq[1] === 1'b1);
    runHi <= (daOut === 1'b1) ? runHi + 1 : 0;
    runLo <= (daOut === 1'b0) ? runLo + 1 : 0;
    if (daOut === 1'b0 && runHi != 0) lastHi <= runHi;
    if (daOut === 1'b1 && runLo != 0) lastLo <= runLo;
    if (cycles == LIMIT) begin
      n_errors++;
      end_of_test();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // entered just after a rising edge; holds the request until pready
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 16) n_errors++;
    @(posedge sys_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(rd, e);
  endtask

  task automatic tick();
    pins_u.drive(0, 1'b1);
    pins_u.drive(0, 1'b0);
    cnt = cnt + 16'h1;
  endtask

  task automatic waitDa(input logic v);
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (daOut !== v && n < 3000);
    if (n == 3000) n_errors++;
  endtask

  function automatic logic [31:0] saCtl(logic c, logic r, logic b,
                                        tccc_pkg::tccc_sa_act_t a, logic q);
    tccc_pkg::tccc_sa_ctrl_t s;
    s = '{irqEn: q, act: a, busSel: b, risePol: r, cmpMode: c};
    return 32'(s);
  endfunction

  function automatic logic [31:0] daCtl(tccc_pkg::tccc_da_mode_t m,
                                        logic f, logic [2:0] k);
    tccc_pkg::tccc_da_ctrl_t c;
    c = '{maskBits: k, firstIrq: f, irqEn: 1'b1, busSel: 1'b0,
          risePol: 1'b1, mode: m};
    return 32'(c);
  endfunction

  task automatic t_regs();
    rdchk(SAC, 32'h0);
    rdchk(DAP, tccc_pkg::RD_ZERO);
    wr(8'h2c, 32'hffff_ffff);
    check(32'(err), 32'h1);
    rdchk(8'h15, 32'h0);
    check(32'(err), 32'h1);
  endtask

  // counters step on the external pin only (rise, then fall), so values
  // stay put between ticks
  task automatic t_count();
    int i0, i1;
    wr(CC0, 32'he);
    wr(CC1, 32'hf);
    wr(tccc_pkg::ADDR_MOD_VAL, 32'hfffd);
    wr(CV1, 32'hfffd);
    wr(CV0, 32'hffff);
    i0 = nC0Irq;
    i1 = nC1Irq;
    tick();
    tick();
    check(nC0Irq - i0, 1);
    check(nC1Irq - i1, 0);
    rdchk(CV1, 32'hffff);
    tick();
    check(nC1Irq - i1, 1);
    rdchk(CV1, 32'hfffd);
    rdchk(CV0, 32'h0002);
  endtask

  task automatic t_sa_cap();
    int i0;
    wr(CV0, 32'habcd_1234);
    wr(CV1, 32'h5678);
    wr(SAC, saCtl(1'b0, 1'b1, 1'b0, tccc_pkg::SA_TOGGLE, 1'b1));
    i0 = nSaIrq;
    pins_u.drive(1, 1'b1);
    rdchk(SAV, 32'h1234);
    check(nSaIrq - i0, 1);
    wr(SAC, saCtl(1'b0, 1'b0, 1'b1, tccc_pkg::SA_TOGGLE, 1'b0));
    pins_u.drive(1, 1'b0);
    rdchk(SAV, 32'h5678);
    check(nSaIrq - i0, 1);
  endtask

  task automatic da_pulse(input logic [15:0] lead, input logic [15:0] trail);
    wr(CV0, {16'h0, lead});
    pins_u.drive(2, 1'b1);
    wr(CV0, {16'h0, trail});
    pins_u.drive(2, 1'b0);
  endtask

  task automatic t_width();
    int i0;
    wr(DAC, daCtl(tccc_pkg::DA_WIDTH, 1'b0, 3'h0));
    i0 = nDaIrq;
    da_pulse(16'h1111, 16'h2222);
    rdchk(DAP, 32'h2222_1111);
    rdchk(DAB, 32'h1111);
    check(nDaIrq - i0, 1);
    wr(DAC, daCtl(tccc_pkg::DA_WIDTH, 1'b1, 3'h0));
    da_pulse(16'h3333, 16'h4444);
    rdchk(DAP, 32'h4444_3333);
    check(nDaIrq - i0, 3);
    // input low for one cycle only: the lead right after a trail counts
    wr(CV0, 32'h5555);
    pins_u.drive(2, 1'b1);
    wr(CV0, 32'h6666);
    pins_u.daIn <= 1'b0;
    @(posedge sys_clk) pins_u.daIn <= 1'b1;
    wr(CV0, 32'h7777);
    pins_u.drive(2, 1'b0);
    rdchk(DAP, 32'h7777_6666);
  endtask

  task automatic t_period();
    int i0;
    wr(DAC, daCtl(tccc_pkg::DA_PERIOD, 1'b0, 3'h0));
    i0 = nDaIrq;
    da_pulse(16'h0100, 16'h0300);
    da_pulse(16'h0300, 16'h0700);
    rdchk(DAP, 32'h0300_0100);
    pins_u.drive(2, 1'b1);
    rdchk(DAP, 32'h0700_0300);
    pins_u.drive(2, 1'b0);
    check(nDaIrq - i0, 3);
  endtask

  task automatic t_sa_cmp();
    tccc_pkg::tccc_sa_act_t acts [4];
    logic [3:0] expOut;
    int e0;
    acts = '{tccc_pkg::SA_TOGGLE, tccc_pkg::SA_CLEAR, tccc_pkg::SA_SET,
             tccc_pkg::SA_HOLD};
    expOut = 4'b1101;
    cnt = 16'h0010;
    wr(CV0, 32'h0010);
    e0 = saEdges;
    for (int i = 0; i < 4; i++) begin
      wr(SAC, saCtl(1'b1, 1'b0, 1'b0, acts[i], 1'b1));
      wr(SAV, {16'h0, cnt + 16'h1});
      tick();
      check(32'(saOut), 32'(expOut[i]));
    end
    check(saEdges - e0, 3);
  endtask

  task automatic t_pulse();
    int i0, e0;
    cnt = 16'h0020;
    wr(CV0, 32'h0020);
    wr(DAC, daCtl(tccc_pkg::DA_PULSE, 1'b1, 3'h0));
    i0 = nDaIrq;
    e0 = daEdges;
    wr(DAA, {16'h0, cnt + 16'h1});
    wr(DAB, {16'h0, cnt + 16'h2});
    tick();
    check(32'(daOut), 32'h1);
    tick();
    check(32'(daOut), 32'h0);
    tick();
    tick();
    check(daEdges - e0, 2);
    check(nDaIrq - i0, 2);
    wr(DAA, {16'h0, cnt + 16'h1});
    tick();
    tick();
    check(daEdges - e0, 3);
    wr(DAC, daCtl(tccc_pkg::DA_PULSE, 1'b0, 3'h0));
    i0 = nDaIrq;
    wr(DAA, {16'h0, cnt + 16'h1});
    wr(DAB, {16'h0, cnt + 16'h2});
    tick();
    tick();
    check(32'(daOut), 32'h0);
    check(nDaIrq - i0, 1);
  endtask

  // seven masked bits give a 512-tick period on the sys/2 tap
  task automatic t_pwm();
    int i0;
    wr(DAC, daCtl(tccc_pkg::DA_PWM, 1'b0, 3'h7));
    wr(DAA, 32'h0010);
    wr(DAB, 32'h0050);
    wr(CC0, 32'h0);
    waitDa(1'b0);
    waitDa(1'b1);
    wr(DAB, 32'h0030);
    waitDa(1'b0);
    i0 = nDaIrq;
    @(posedge sys_clk);
    check(lastHi, 128);
    waitDa(1'b1);
    waitDa(1'b0);
    @(posedge sys_clk);
    check(lastHi, 64);
    check(lastLo, 896);
    check(nDaIrq - i0, 1);
  endtask

  task automatic end_of_test();
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    {n_errors, cmp_count, cycles, nSaIrq, nDaIrq, nC0Irq, nC1Irq} = 0;
    {runHi, runLo, lastHi, lastLo} = 0;
    {psel, penable, pwrite, paddr, pwdata, cnt} = 0;
    reset = 1'b1;
    repeat (6) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    t_regs();
    t_count();
    t_sa_cap();
    t_width();
    t_period();
    t_sa_cmp();
    t_pulse();
    t_pwm();
    end_of_test();
  end
endmodule // tb_timer_capture_compare_channels
